// ===== hw/vcc_cfg.svh
// Offsets, field positions, reset values and timing counts of the channel capability block.
`ifndef VCC_CFG_SVH
`define VCC_CFG_SVH
`define VCC_OFF_HEADER       12'h140
`define VCC_OFF_CAP_ONE      12'h144
`define VCC_OFF_CAP_TWO      12'h148
`define VCC_OFF_CTRL_STAT    12'h14c
`define VCC_OFF_TBL_CMD      12'h160
`define VCC_OFF_TBL_DONE     12'h164
`define VCC_CAP_ID           16'h0002
`define VCC_CAP_VERSION      4'h1
`define VCC_NEXT_PTR         12'h20c
`define VCC_EXT_HI_RST       2'h0
`define VCC_LPG_RST          3'h0
`define VCC_REF_CLK          2'h0
`define VCC_ENTRY_SIZE       2'h2
`define VCC_ARB_CAP_ON       8'h03
`define VCC_ARB_CAP_OFF      8'h00
`define VCC_TBL_OFF_ON       8'h03
`define VCC_TBL_OFF_OFF      8'h00
`define VCC_SEL_RST          3'h0
`define VCC_SEL_MAX          3'h1
`define VCC_CTRL_LOAD_BIT    0
`define VCC_STAT_TBL_BIT     16
`define VCC_LOAD_CYCLES      4'h8
`endif

// ===== hw/vcc_load_if.sv
// Load request and completion signals between the register file and the table loader.
`timescale 1ns/10ps
`default_nettype none
interface vcc_load_if;
  logic start;
  logic busy;
  logic done;
  modport regs   (output start, input busy, input done);
  modport loader (input start, output busy, output done);
endinterface
`default_nettype wire

// ===== hw/vcc_loader.sv
// Table loader that applies the arbitration table over a fixed number of cycles.
`timescale 1ns/10ps
`include "vcc_cfg.svh"
`default_nettype none
module vcc_loader (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  vcc_load_if.loader lif
);
  vcc_pkg::vcc_load_state_t state;
  vcc_pkg::vcc_load_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       done_q;
  logic       next_done;
  assign lif.busy = (state == vcc_pkg::VCC_LD_BUSY);
  assign lif.done = done_q;
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_done  = 1'b0;
    if (ce) begin
      case (state)
        vcc_pkg::VCC_LD_IDLE: begin
          if (lif.start) begin
            next_state = vcc_pkg::VCC_LD_BUSY;
            next_cnt   = `VCC_LOAD_CYCLES;
          end
        end
        vcc_pkg::VCC_LD_BUSY: begin
          next_cnt = cnt - 4'h1;
          if (cnt == 4'h1) begin
            next_state = vcc_pkg::VCC_LD_IDLE;
            next_done  = 1'b1;
          end
        end
        default: next_state = vcc_pkg::VCC_LD_IDLE;
      endcase
    end else begin
      next_done = done_q;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state  <= vcc_pkg::VCC_LD_IDLE;
      cnt    <= 4'h0;
      done_q <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      done_q <= next_done;
    end
  end
  a_load_length: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !lif.busy && lif.start) ##1 ce[*8] |=> lif.done)
    else $error("table load did not finish in eight cycles");
endmodule
`default_nettype wire

// ===== hw/vcc_pkg.sv
// Types shared by the channel capability block.
package vcc_pkg;
  typedef enum logic [1:0] {VCC_IDLE, VCC_ADDR, VCC_DATA} vcc_bus_state_t;
  typedef enum logic [0:0] {VCC_LD_IDLE, VCC_LD_BUSY} vcc_load_state_t;
endpackage

// ===== hw/vcc_regs.sv
// Channel capability register bank on an AHB-Lite slave port.
//
// Notes on behaviour
// - The header low half reads 0002h as the channel capability identifier.
// - Header bits 19 to 16 read the structure version 1h.
// - Header bits 31 to 20 read the next capability pointer 20Ch.
// - Channel count bits 2 to 1 reset to zero and bit 0 follows the strap at reset.
// - Low-priority group count in bits 6 to 4 resets to zero.
// - Reference clock field in bits 9 to 8 reads 00b for 100 ns.
// - Table entry size field in bits 11 to 10 reads 10b for 4-bit entries.
// - Channel arbitration capability reads 03h when count bit 0 is set, else 00h.
// - That capability is meaningful only while the low-priority count is above zero.
// - Table location in bits 31 to 24 reads 03h when count bit 0 is set, else 00h.
// - Writing 1 to control bit 0 starts a table load and the bit reads back 0.
// - Arbitration select accepts 0 or 1 only, other writes give the default 0.
// - Status bit 16 sets on any table entry write and clears when a load finishes.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "vcc_cfg.svh"
`default_nettype none
module vcc_regs (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        second_channel_strap,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [2:0]       arb_select,
  output logic             table_pending,
  output logic             load_busy
);
  vcc_load_if lif ();
  logic        strap_s;
  logic        ext_lo;
  logic        next_ext_lo;
  logic [1:0]  strap_taken;
  logic [1:0]  next_strap_taken;
  logic [2:0]  sel;
  logic [2:0]  next_sel;
  logic        tbl_stat;
  logic        next_tbl_stat;
  logic        start;
  logic        next_start;
  logic        wr_pend;
  logic        next_wr_pend;
  logic [11:0] wr_addr;
  logic [11:0] next_wr_addr;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        busy_q;
  logic        next_busy_q;
  logic [31:0] cap_one;
  logic [31:0] cap_two;
  logic [31:0] header;
  logic [2:0]  ext_cnt;
  logic [2:0]  lpg_cnt;
  logic        addr_ok;
  logic        wr_ctrl;
  logic        wr_tbl;
  logic [2:0]  wsel;

  vcc_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       (second_channel_strap),
    .q       (strap_s)
  );

  vcc_loader u_loader (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .lif     (lif)
  );

  assign lif.start = start;
  assign ext_cnt   = {`VCC_EXT_HI_RST, ext_lo};
  assign lpg_cnt   = `VCC_LPG_RST;
  assign header    = {`VCC_NEXT_PTR, `VCC_CAP_VERSION, `VCC_CAP_ID};
  // The capability is reported from count bit 0; software checks the group count first.
  assign cap_one   = {20'h00000, `VCC_ENTRY_SIZE, `VCC_REF_CLK, 1'b0, lpg_cnt,
                      1'b0, ext_cnt};
  assign cap_two   = {(ext_lo ? `VCC_TBL_OFF_ON : `VCC_TBL_OFF_OFF), 16'h0000,
                      (ext_lo ? `VCC_ARB_CAP_ON : `VCC_ARB_CAP_OFF)};
  assign wsel      = (hwdata[3:1] <= `VCC_SEL_MAX) ? hwdata[3:1] : `VCC_SEL_RST;
  assign wr_ctrl   = wr_pend && (wr_addr == `VCC_OFF_CTRL_STAT);
  assign wr_tbl    = wr_pend && (wr_addr == `VCC_OFF_TBL_CMD);

  // Address decode for reads.
  always_comb begin
    addr_ok    = 1'b1;
    next_rdata = 32'h00000000;
    case (haddr[11:0])
      `VCC_OFF_HEADER:    next_rdata = header;
      `VCC_OFF_CAP_ONE:   next_rdata = cap_one;
      `VCC_OFF_CAP_TWO:   next_rdata = cap_two;
      `VCC_OFF_CTRL_STAT: next_rdata = {15'h0000, tbl_stat, 12'h000, sel, 1'b0};
      `VCC_OFF_TBL_CMD:   next_rdata = 32'h00000000;
      `VCC_OFF_TBL_DONE:  next_rdata = {31'h00000000, lif.busy};
      default:            addr_ok    = 1'b0;
    endcase
    if (!addr_ok) begin
      next_rdata = 32'h00000000;
    end
    if (!(ce && hsel && hready && htrans[1] && !hwrite)) begin
      next_rdata = rdata;
    end
  end

  // Bus phases, control, strap capture and table status.
  always_comb begin
    next_wr_pend     = wr_pend;
    next_wr_addr     = wr_addr;
    next_sel         = sel;
    next_tbl_stat    = tbl_stat;
    next_start       = 1'b0;
    next_ext_lo      = ext_lo;
    next_strap_taken = strap_taken;
    next_busy_q      = busy_q;
    if (ce) begin
      next_busy_q = lif.busy;
      if (strap_taken != 2'h3) begin
        next_strap_taken = strap_taken + 2'h1;
      end
      if (strap_taken == 2'h2) begin
        next_ext_lo = strap_s;
      end
      next_wr_pend = hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        next_wr_addr = haddr[11:0];
      end
      if (wr_ctrl) begin
        next_sel   = wsel;
        next_start = hwdata[`VCC_CTRL_LOAD_BIT];
      end
      if (lif.done) begin
        next_tbl_stat = 1'b0;
      end
      if (wr_tbl) begin
        next_tbl_stat = 1'b1;
      end
    end else begin
      next_start = start;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend     <= 1'b0;
      wr_addr     <= 12'h000;
      rdata       <= 32'h00000000;
      sel         <= `VCC_SEL_RST;
      tbl_stat    <= 1'b0;
      start       <= 1'b0;
      ext_lo      <= 1'b0;
      strap_taken <= 2'h0;
      busy_q      <= 1'b0;
    end else begin
      wr_pend     <= next_wr_pend;
      wr_addr     <= next_wr_addr;
      rdata       <= next_rdata;
      sel         <= next_sel;
      tbl_stat    <= next_tbl_stat;
      start       <= next_start;
      ext_lo      <= next_ext_lo;
      strap_taken <= next_strap_taken;
      busy_q      <= next_busy_q;
    end
  end

  assign hrdata        = rdata;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign arb_select    = sel;
  assign table_pending = tbl_stat;
  assign load_busy     = busy_q;

  a_sel_legal: assert property (@(posedge hclk) disable iff (!hresetn)
    sel <= `VCC_SEL_MAX)
    else $error("arbitration select holds an illegal value");

  a_sel_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && wr_ctrl) |=> (sel == $past(wsel)))
    else $error("arbitration select write not taken");

  a_sel_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !wr_ctrl) |=> $stable(sel))
    else $error("arbitration select changed without a write");

  a_load_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && wr_ctrl && hwdata[0]) |=> start ##1 (lif.busy || !ce))
    else $error("load request did not start the loader");

  a_start_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && start && !wr_ctrl) |=> !start)
    else $error("load request held longer than one cycle");

  a_stat_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && wr_tbl) |=> tbl_stat)
    else $error("table status not set by entry write");

  a_stat_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && lif.done && !wr_tbl) |=> !tbl_stat)
    else $error("table status not cleared after load");

  a_stat_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !wr_tbl && !lif.done) |=> $stable(tbl_stat))
    else $error("table status changed without a cause");

  a_header_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
    header == 32'h20c10002)
    else $error("capability header value wrong");

  a_header_id: assert property (@(posedge hclk) disable iff (!hresetn)
    header[15:0] == 16'h0002)
    else $error("capability identifier wrong");

  a_header_version: assert property (@(posedge hclk) disable iff (!hresetn)
    header[19:16] == 4'h1)
    else $error("capability version wrong");

  a_header_next: assert property (@(posedge hclk) disable iff (!hresetn)
    header[31:20] == 12'h20c)
    else $error("next capability pointer wrong");

  a_count_high: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_cnt[2:1] == 2'h0)
    else $error("channel count upper bits not zero");

  a_strap_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && strap_taken == 2'h2) |=> (ext_lo == $past(strap_s)))
    else $error("strap level not captured into the channel count");

  a_count_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (strap_taken == 2'h3) |=> $stable(ext_lo))
    else $error("channel count changed after capture");

  a_group_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    lpg_cnt == 3'h0)
    else $error("low-priority group count not zero");

  a_ref_clock: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_one[9:8] == 2'h0)
    else $error("reference clock field wrong");

  a_entry_size: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_one[11:10] == 2'h2)
    else $error("table entry size field wrong");

  a_cap_one_res: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_one[31:12] == 20'h00000 && cap_one[11:8] == 4'h8 && cap_one[6:1] == 6'h00)
    else $error("capability one fixed fields wrong");

  a_cap_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_two[7:0] == (cap_one[0] ? 8'h03 : 8'h00) && cap_two[31:24] == cap_two[7:0])
    else $error("arbitration capability does not track the count");

  a_cap_two_res: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_two[23:8] == 16'h0000)
    else $error("capability two reserved bits not zero");

  a_table_loc: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_two[31:24] == (ext_lo ? 8'h03 : 8'h00))
    else $error("table location does not track the count");

  a_ctrl_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && hsel && hready && htrans[1] && !hwrite && haddr[11:0] == `VCC_OFF_CTRL_STAT)
      |=> (hrdata[0] == 1'b0 && hrdata[3:1] == $past(sel)))
    else $error("control read back wrong");

  a_ctrl_status: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && hsel && hready && htrans[1] && !hwrite && haddr[11:0] == `VCC_OFF_CTRL_STAT)
      |=> (hrdata[16] == $past(tbl_stat)))
    else $error("table status read back wrong");

  a_ctrl_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && hsel && hready && htrans[1] && !hwrite && haddr[11:0] == `VCC_OFF_CTRL_STAT)
      |=> (hrdata[31:17] == 15'h0000 && hrdata[15:4] == 12'h000))
    else $error("control reserved bits not zero");

  a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && hsel && hready && htrans[1] && !hwrite && !addr_ok) |=> (hrdata == 32'h00000000))
    else $error("unmapped read returned data");

  a_read_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (!(ce && hsel && hready && htrans[1] && !hwrite)) |=> $stable(hrdata))
    else $error("read data changed without a read");

  a_write_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && hsel && hready && htrans[1] && hwrite) |=> wr_pend)
    else $error("write address phase not taken");

  a_freeze_state: assert property (@(posedge hclk) disable iff (!hresetn)
    (!ce) |=> ($stable(sel) && $stable(tbl_stat) && $stable(start) && $stable(ext_lo)))
    else $error("state changed while the clock enable was low");

  a_busy_mirror: assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> (busy_q == $past(lif.busy)))
    else $error("busy output does not follow the loader");

  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus response not ready and okay");
endmodule
`default_nettype wire

// ===== hw/vcc_sync.sv
// Two flip-flop synchroniser for the strap level.
`timescale 1ns/10ps
`default_nettype none
module vcc_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  logic meta;
  logic next_meta;
  logic next_q;
  always_comb begin
    next_meta = ce ? d : meta;
    next_q    = ce ? meta : q;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the channel capability register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic        w;
    logic [31:0] a;
    logic [31:0] d;
    logic [2:0]  s;
  } vcc_tb_row_t;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        strap;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [2:0]  arb_select;
  logic        table_pending;
  logic        load_busy;
  logic [31:0] rd;
  int          bad_count;
  int          num_checks;
  int          cyc;
  int          n;
  vcc_tb_row_t rows [13] = '{
    '{1'b0, 32'h140, 32'h20c10002, 3'h0}, '{1'b1, 32'h140, 32'hffffffff, 3'h0},
    '{1'b0, 32'h140, 32'h20c10002, 3'h0}, '{1'b0, 32'h144, 32'h00000801, 3'h0},
    '{1'b0, 32'h148, 32'h03000003, 3'h0}, '{1'b0, 32'h14c, 32'h00000000, 3'h0},
    '{1'b1, 32'h14c, 32'h00000002, 3'h1}, '{1'b0, 32'h14c, 32'h00000002, 3'h1},
    '{1'b1, 32'h14c, 32'h0000000a, 3'h0}, '{1'b0, 32'h14c, 32'h00000000, 3'h0},
    '{1'b1, 32'h14c, 32'hfffeeff2, 3'h1}, '{1'b0, 32'h14c, 32'h00000002, 3'h1},
    '{1'b0, 32'h200, 32'h00000000, 3'h1}};
  vcc_regs u_dut (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .ce                   (ce),
    .second_channel_strap (strap),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hreadyout),
    .hrdata               (hrdata),
    .hreadyout            (hreadyout),
    .hresp                (hresp),
    .arb_select           (arb_select),
    .table_pending        (table_pending),
    .load_busy            (load_busy)
  );
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic do_reset(input logic s);
    @(posedge hclk);
    hresetn <= 1'b0;
    strap   <= s;
    repeat (16) @(posedge hclk);
    @(negedge hclk);
    chk({hrdata[3:0], arb_select, table_pending, load_busy}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    strap = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    do_reset(1'b1);
    for (int i = 0; i < 13; i++) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (rows[i].w == 1'b0) chk(rd, rows[i].d);
      @(negedge hclk);
      chk({29'h0, arb_select}, {29'h0, rows[i].s});
    end
    $display("table rows done");
    bus(1'b1, 32'h160, 32'h5);
    bus(1'b0, 32'h14c, 32'h0);
    chk(rd, 32'h00010002);
    bus(1'b1, 32'h14c, 32'h3);
    bus(1'b0, 32'h164, 32'h0);
    chk(rd, 32'h00000001);
    n = 0;
    while (load_busy !== 1'b1 && n < 10) begin
      @(negedge hclk);
      n++;
    end
    chk({31'h0, load_busy}, 32'h1);
    chk({31'h0, table_pending}, 32'h1);
    n = 0;
    while (load_busy !== 1'b0 && n < 20) begin
      @(negedge hclk);
      n++;
    end
    chk(n, 32'h8);
    bus(1'b0, 32'h14c, 32'h0);
    chk(rd, 32'h00000002);
    $display("table load done");
    ce <= 1'b0;
    bus(1'b1, 32'h14c, 32'h0);
    ce <= 1'b1;
    bus(1'b0, 32'h14c, 32'h0);
    chk(rd, 32'h00000002);
    $display("clock enable freeze done");
    do_reset(1'b0);
    bus(1'b0, 32'h144, 32'h0);
    chk(rd, 32'h00000800);
    bus(1'b0, 32'h148, 32'h0);
    chk(rd, 32'h00000000);
    $display("strap low reset done");
    end_sim();
  end
endmodule
`default_nettype wire
